//--- src/ref_select_defs.svh
// constants for the reference-input select and status edge-rate block
// assumes inclusion by bare name from design files under src/
`ifndef REF_SELECT_DEFS_SVH
`define REF_SELECT_DEFS_SVH
// register indices, byte address is four times the index
`define IDX_EDGE_RATE 8'h31
`define IDX_INPUT_SEL 8'h32
`define ADDR_EDGE_RATE 12'hc4
`define ADDR_INPUT_SEL 12'hc8
// status output source register, neighbouring, offset chosen here
`define ADDR_AUX_SOURCE 12'hcc
// resolved-state readback register, offset chosen here
`define ADDR_LOOP_STATE 12'hd0
`define RST_EDGE_RATE 8'h00
`define RST_INPUT_SEL 8'h95
`define RST_AUX_SOURCE 8'h0a
`define EDGE_FAST 2'h0
`define EDGE_SLOW 2'h2
`define SRC_AUTO 2'h0
`define SRC_PIN 2'h1
`define SRC_PRI 2'h2
`define SRC_SEC 2'h3
`define AUX_SRC_NORMAL 2'h2
`define AUX_SRC_OFF 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- src/ref_select_pkg.sv
// types for the reference-input select and status edge-rate block
// assumes nothing beyond a SystemVerilog compiler
package ref_select_pkg;
   typedef enum logic [1:0] {
      buf_single, buf_diff, buf_xtal, buf_off
   } buf_mode_t;
   typedef enum logic [1:0] {pin_low, pin_mid, pin_high, pin_bad} pin_level_t;
   typedef struct packed {
      logic [7:0] edge_rate;
      logic [7:0] input_sel;
      logic [7:0] aux_source;
   } regs_t;
   typedef struct packed {
      buf_mode_t primary_buffer_mode;
      buf_mode_t secondary_buffer_mode;
      logic first_aux_slow;
      logic second_aux_slow;
      logic [1:0] first_aux_source;
      logic [1:0] second_aux_source;
      logic use_secondary;
      logic auto_mode;
   } cfg_out_t;
endpackage : ref_select_pkg

//--- src/ref_pin_decode.sv
// three-level select pin decoder
// assumes the pad supplies two comparator levels, both asynchronous
`timescale 1ns/1ps
`include "ref_select_defs.svh"
module ref_pin_decode (
   input wire logic mclk, // 250 MHz clock
   input wire logic rstn, // sync reset, active low
   input wire logic ce, // clock enable
   input wire logic above_low, // pad level above low threshold
   input wire logic above_mid, // pad level above mid threshold
   output ref_select_pkg::pin_level_t level // synchronised level
);
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      ref_select_pkg::pin_level_t lvl;
   } state_t;
   state_t q, d;
   always_comb begin
      d = q;
      d.s1 = {above_mid, above_low};
      d.s2 = q.s1;
      case (q.s2)
         2'h0: d.lvl = ref_select_pkg::pin_low;
         2'h1: d.lvl = ref_select_pkg::pin_mid;
         2'h3: d.lvl = ref_select_pkg::pin_high;
         // inconsistent comparators: keep the last good level
         default: d.lvl = q.lvl;
      endcase
   end
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         q <= '{s1: 2'h0, s2: 2'h0, lvl: ref_select_pkg::pin_low};
      end else if (ce) begin
         q <= d;
      end
   end
   assign level = q.lvl;
endmodule : ref_pin_decode

//--- src/ref_input_select_cfg.sv
// register block for reference selection and status output edge rate
// assumes an AXI4-Lite master on mclk; pad levels and usable flags are
// asynchronous and are synchronised here
// reserved input-select bits are stored as written and read back
//
// Notes on behaviour
// - second status output edge rate resets fast; 0 fast, 2 slow.
// - first status output edge rate resets fast; 0 fast, 2 slow.
// - secondary buffer: 0 single, 1 diff, 2 crystal, 3 off; resets crystal.
// - primary buffer: 0 single, 1 diff, 2 and 3 off; resets diff.
// - loop source: 0 auto, 1 pin, 2 primary, 3 secondary; resets to 1.
// - auto mode picks primary whenever it is usable.
// - the select pin counts only while the loop source is 1.
// - pin low is primary, mid is secondary, high is automatic.
// - each status pin has its own source selector; edge rate applies.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ref_select_defs.svh"
module ref_input_select_cfg (
   input wire logic mclk, // 250 MHz clock
   input wire logic rstn, // sync reset, active low
   input wire logic ce, // clock enable, freezes state when low
   input wire logic [11:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [11:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   input wire logic pin_above_low, // select pin above low threshold
   input wire logic pin_above_mid, // select pin above mid threshold
   input wire logic primary_usable, // primary reference present, async
   output ref_select_pkg::cfg_out_t cfg // decoded settings, registered
);
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      ref_select_pkg::regs_t regs;
      logic aw_have;
      logic [11:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] pri_sync;
      ref_select_pkg::cfg_out_t out;
   } state_t;
   state_t q, d;
   ref_select_pkg::pin_level_t pin_level;
   // select pin levels pass three flops inside the decoder: two sync flops, then the level register
   ref_pin_decode u_pin (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .above_low(pin_above_low),
      .above_mid(pin_above_mid),
      .level(pin_level)
   );
   ////////////////////////////////////////////////////////////////////
   // only byte lane 0 carries register data; other lanes are ignored
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
      merge = strb[0] ? data[7:0] : old;
   endfunction : merge
   logic [1:0] src;
   logic [1:0] pri_field;
   logic [1:0] sec_field;
   logic [7:0] state_word;
   logic [1:0] aux_slow;
   logic [1:0][1:0] aux_src;
   logic [31:0] rd_word;
   logic rd_err;
   ////////////////////////////////////////////////////////////////////
   // per status pin, pin 0 first
   // two pins share one decode; the loop keeps them alike
   for (genvar p = 0; p < 2; p++) begin : g_aux
      // reserved codes 1 and 3 fall back to fast edges
      assign aux_slow[p] = (q.regs.edge_rate[2*p +: 2] == `EDGE_SLOW);
      assign aux_src[p] = q.regs.aux_source[2*p +: 2];
   end
   ////////////////////////////////////////////////////////////////////
   // read mux; unmapped offsets answer zero with an error response
   always_comb begin
      rd_word = 32'h0;
      rd_err = 1'b0;
      case (s_axi_araddr)
         `ADDR_EDGE_RATE: rd_word = {24'h0, q.regs.edge_rate};
         `ADDR_INPUT_SEL: rd_word = {24'h0, q.regs.input_sel};
         `ADDR_AUX_SOURCE: rd_word = {24'h0, q.regs.aux_source};
         `ADDR_LOOP_STATE: rd_word = {24'h0, state_word};
         default: rd_err = 1'b1;
      endcase
   end
   ////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      src = q.regs.input_sel[1:0];
      pri_field = q.regs.input_sel[5:4];
      sec_field = q.regs.input_sel[7:6];
      // live status word; bit 0 is spare and reads zero
      state_word = {4'h0, q.out.auto_mode, q.out.use_secondary,
                    q.pri_sync[1], 1'b0};
      // capture address and data independently, either order
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_have = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      // one write at a time: readys stay low until the answer is taken
      if (q.aw_have && q.w_have && !q.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = `RESP_OKAY;
         case (q.aw_addr)
            // edge rate reg, upper nibble reserved reads zero
            `ADDR_EDGE_RATE: d.regs.edge_rate =
               merge(q.regs.edge_rate, q.w_data, q.w_strb);
            `ADDR_INPUT_SEL: d.regs.input_sel =
               merge(q.regs.input_sel, q.w_data, q.w_strb);
            `ADDR_AUX_SOURCE: d.regs.aux_source =
               merge(q.regs.aux_source, q.w_data, q.w_strb);
            `ADDR_LOOP_STATE: d.bresp = `RESP_OKAY;
            default: d.bresp = `RESP_SLVERR;
         endcase
         // both narrow regs keep only their low nibble
         d.regs.edge_rate[7:4] = 4'h0;
         d.regs.aux_source[7:4] = 4'h0;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         d.rvalid = 1'b1;
         d.rdata = rd_word;
         d.rresp = rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // only the second flop of the sync feeds selection logic
      d.pri_sync = {q.pri_sync[0], primary_usable};
      ////////////////////////////////////////////////////////////////
      // status output edge rates and sources, buffer modes, loop source
      d.out.first_aux_slow = aux_slow[0];
      d.out.second_aux_slow = aux_slow[1];
      d.out.first_aux_source = aux_src[0];
      d.out.second_aux_source = aux_src[1];
      d.out.secondary_buffer_mode = ref_select_pkg::buf_mode_t'(sec_field);
      // primary buffer decode, codes 2 and 3 both disable
      d.out.primary_buffer_mode = pri_field[1] ? ref_select_pkg::buf_off :
         ref_select_pkg::buf_mode_t'(pri_field);
      case (src)
         `SRC_AUTO: d.out.auto_mode = 1'b1;
         // pin consulted only in this code
         `SRC_PIN: d.out.auto_mode = (pin_level == ref_select_pkg::pin_high);
         default: d.out.auto_mode = 1'b0;
      endcase
      case (src)
         `SRC_SEC: d.out.use_secondary = 1'b1;
         `SRC_PRI: d.out.use_secondary = 1'b0;
         `SRC_PIN: begin
            // low primary, mid secondary, high automatic
            case (pin_level)
               ref_select_pkg::pin_mid: d.out.use_secondary = 1'b1;
               ref_select_pkg::pin_high: d.out.use_secondary = !q.pri_sync[1];
               // pin low, and pin_bad which the decoder never emits
               default: d.out.use_secondary = 1'b0;
            endcase
         end
         default: d.out.use_secondary = !q.pri_sync[1];
      endcase
   end
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         q <= '0;
         q.regs.edge_rate <= `RST_EDGE_RATE;
         // source resets to pin mode, buffers diff and crystal
         q.regs.input_sel <= `RST_INPUT_SEL;
         q.regs.aux_source <= `RST_AUX_SOURCE;
         // cfg starts as the decode of the reset register values
         q.out.primary_buffer_mode <= ref_select_pkg::buf_diff;
         q.out.secondary_buffer_mode <= ref_select_pkg::buf_xtal;
         q.out.first_aux_source <= `AUX_SRC_NORMAL;
         q.out.second_aux_source <= `AUX_SRC_NORMAL;
      end else if (ce) begin
         q <= d;
      end
   end
   // readys fall with ce so nothing is taken while state is frozen
   assign s_axi_awready = !q.aw_have && !q.bvalid && ce;
   assign s_axi_wready = !q.w_have && !q.bvalid && ce;
   assign s_axi_arready = !q.rvalid && ce;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign cfg = q.out;
endmodule : ref_input_select_cfg

//--- verif/ref_select_properties.sv
// checker: bus answer holds, decode of settings, forced sources
// assumes binding onto ref_input_select_cfg, single clock domain
`timescale 1ns/1ps
module ref_select_properties (
   input wire logic mclk, // clock
   input wire logic rstn, // reset, low
   input wire logic ce, // enable
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [11:0] s_axi_araddr, // read addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [1:0] s_axi_rresp, // read resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic primary_usable, // usable flag
   input wire ref_select_pkg::cfg_out_t cfg // settings
);
   logic [11:0] ar_q;
   logic [2:0] cnt_q;
   logic pu_q;
   wire rb = s_axi_rvalid && s_axi_rresp == 2'h0;
   // stable-usable count covers the two-flop sync plus cfg register
   always_ff @(posedge mclk) begin
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (!rstn || !ce || primary_usable != pu_q) cnt_q <= 3'h0;
      else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
      pu_q <= primary_usable;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////
   chk_reset_state:
   assert property ($rose(rstn) |-> !cfg.first_aux_slow &&
      !cfg.second_aux_slow && cfg.primary_buffer_mode == 2'h1 &&
      cfg.secondary_buffer_mode == 2'h2) else $error("reset state");
   chk_primary_no_xtal:
   assert property (cfg.primary_buffer_mode != 2'h2) else $error("pri");
   chk_auto_prefers:
   assert property (cnt_q == 3'h7 && cfg.auto_mode |->
      cfg.use_secondary == !primary_usable) else $error("auto pick");
   chk_edge_decode:
   assert property (rb && ar_q == 12'hc4 |-> s_axi_rdata[31:4] == 0 &&
      cfg.first_aux_slow == (s_axi_rdata[1:0] == 2'h2) &&
      cfg.second_aux_slow == (s_axi_rdata[3:2] == 2'h2)) else $error("edge");
   chk_buf_decode:
   assert property (rb && ar_q == 12'hc8 |->
      cfg.secondary_buffer_mode == s_axi_rdata[7:6] &&
      cfg.primary_buffer_mode == (s_axi_rdata[5] ? 2'h3 : s_axi_rdata[5:4]))
      else $error("buffer mode");
   chk_forced_src:
   assert property (rb && ar_q == 12'hc8 && s_axi_rdata[1] |->
      !cfg.auto_mode && cfg.use_secondary == s_axi_rdata[0])
      else $error("forced source");
   chk_aux_source:
   assert property (rb && ar_q == 12'hcc |->
      {cfg.second_aux_source, cfg.first_aux_source} == s_axi_rdata[3:0])
      else $error("aux source");
   chk_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read answer");
   chk_rdata_hold:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata)) else $error("read dropped");
   chk_bvalid_hold:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("b dropped");
   chk_frozen_ce:
   assert property (!ce |-> !s_axi_arready) else $error("ready with ce low");
endmodule : ref_select_properties
bind ref_input_select_cfg ref_select_properties u_props (.mclk(mclk),
   .rstn(rstn), .ce(ce), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .primary_usable(primary_usable), .cfg(cfg));

//--- verif/ref_input_select_cfg_tb.sv
// random plus corner bench for the reference select register block
// assumes the design and its checker are compiled before it
`timescale 1ns/1ps
module ref_input_select_cfg_tb;
   logic mclk = 0, rstn = 0, ce = 1, awv = 0, wv = 0, br = 0, arv = 0;
   logic rr = 0, plo = 0, pmi = 0, pu = 0, bv, rv, awr, wr_, arr;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, d, v;
   logic [1:0] bresp, rresp, r, lv;
   ref_select_pkg::cfg_out_t cfg;
   int failures = 0, compares = 0;
   always #2 mclk = ~mclk;
   ref_input_select_cfg u_dut (.mclk(mclk), .rstn(rstn), .ce(ce),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(d), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .pin_above_low(plo),
      .pin_above_mid(pmi), .primary_usable(pu), .cfg(cfg));
   ////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic hang;
      failures++;
      $display("Error %0t: no answer", $time);
      tally_and_finish();
   endtask : hang
   // ready may come late: a random start stalls the answer
   task automatic wr(input logic [11:0] a, input logic [31:0] x);
      awa <= a;
      wd <= x;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'($urandom());
      for (int n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (awr) awv <= 1'b0;
         if (wr_) wv <= 1'b0;
         if (bv && br) begin
            br <= 1'b0;
            r = bresp;
            @(posedge mclk);
            return;
         end
         if (!br) br <= 1'($urandom());
      end
      hang();
   endtask : wr
   task automatic rd(input logic [11:0] a);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'($urandom());
      for (int n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (arr) arv <= 1'b0;
         if (rv && rr) begin
            rr <= 1'b0;
            v = d;
            r = rresp;
            @(posedge mclk);
            return;
         end
         if (!rr) rr <= 1'($urandom());
      end
      hang();
   endtask : rd
   // returns {use_secondary, auto_mode}; lv is {above_mid, above_low}
   function automatic logic [1:0] sel_exp(input logic [1:0] s, l,
      input logic u);
      if (s == 2'h0 || (s == 2'h1 && l == 2'h3)) return {~u, 1'b1};
      if (s == 2'h1) return {l[0], 1'b0};
      return {s[0], 1'b0};
   endfunction : sel_exp
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hbf60));
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      plo <= 1'b1;
      pu <= 1'b1;
      @(posedge mclk);
      rd(12'hc4);
      chk(v, 32'h0);
      rd(12'hc8);
      chk(v, 32'h95);
      rd(12'hcc);
      chk(v, 32'h0a);
      repeat (6) @(posedge mclk);
      chk(32'({cfg.use_secondary, cfg.auto_mode}), 32'h2);
      for (int i = 0; i < 16; i++) begin
         wr(12'hc4, {$urandom()} & 32'hfffffff0 | 32'(i));
         rd(12'hc4);
         chk(v, 32'(i));
         chk(32'({cfg.second_aux_slow, cfg.first_aux_slow}),
            32'({i[3:2] == 2'h2, i[1:0] == 2'h2}));
         wr(12'hc8, {$urandom()} & 32'hff03 | 32'h4 | 32'(i << 4));
         rd(12'hc8);
         chk(32'(cfg.primary_buffer_mode),
            i[1] ? 32'h3 : 32'(i[1:0]));
         chk(32'(cfg.secondary_buffer_mode), 32'(i[3:2]));
      end
      for (int k = 0; k < 24; k++) begin
         lv = (k / 4) % 3 == 2 ? 2'h3 : 2'((k / 4) % 3);
         {pmi, plo} <= lv;
         pu <= 1'(k < 12);
         rd(12'hc8);
         wr(12'hc8, {v[31:2], 2'(k)});
         repeat (6) @(posedge mclk);
         chk(32'({cfg.use_secondary, cfg.auto_mode}),
            32'(sel_exp(2'(k), lv, k < 12)));
      end
      wr(12'hcc, $urandom());
      rd(12'hcc);
      chk(v, wd & 32'hf);
      chk(32'({cfg.second_aux_source, cfg.first_aux_source}),
         wd & 32'hf);
      rd(12'h100);
      chk({v[29:0], r}, {30'h0, 2'h2});
      wr(12'h104, 32'hff);
      chk(32'(r), 32'h2);
      wr(12'hd0, 32'hff);
      chk(32'(r), 32'h0);
      // pin mode, pin high, primary lost: automatic on the secondary
      rd(12'hc8);
      wr(12'hc8, {v[31:2], 2'h1});
      repeat (6) @(posedge mclk);
      rd(12'hd0);
      chk(v, 32'hc);
      // frozen: a pin move under ce low must not reach cfg
      ce <= 1'b0;
      {pmi, plo} <= 2'h0;
      repeat (8) @(posedge mclk);
      chk(32'({cfg.use_secondary, cfg.auto_mode}), 32'h3);
      ce <= 1'b1;
      repeat (6) @(posedge mclk);
      chk(32'({cfg.use_secondary, cfg.auto_mode}), 32'h0);
      tally_and_finish();
   end
endmodule : ref_input_select_cfg_tb
